// *** hdl/clock_select_pkg.sv ***
// constants, types and register map for the system clock source selector
package clock_select_pkg;

  // bus register offsets (byte addresses)
  localparam logic [3:0] MODE_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] FREQ_OFFSET = 4'h8;

  // mode register field positions
  localparam int SOURCE_LSB = 0;
  localparam int GAIN_LSB = 4;
  localparam int PLL_ON_BIT = 8;
  localparam int TAP_LSB = 12;

  // clock sources
  localparam logic [2:0] SRC_INTERNAL_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_INTERNAL_SLOW_RC = 3'h1;
  localparam logic [2:0] SRC_EXTERNAL_CLOCK = 3'h2;
  localparam logic [2:0] SRC_CRYSTAL = 3'h3;

  // oscillator gain settings
  localparam logic [1:0] GAIN_OFF = 2'h0;
  localparam logic [1:0] GAIN_CRYSTAL_LOW = 2'h1;
  localparam logic [1:0] GAIN_CRYSTAL_MID = 2'h2;
  localparam logic [1:0] GAIN_CRYSTAL_HIGH = 2'h3;

  // pll taps, value is log2 of the factor
  localparam logic [2:0] TAP_TIMES_ONE = 3'h0;
  localparam logic [2:0] TAP_TIMES_TWO = 3'h1;
  localparam logic [2:0] TAP_TIMES_FOUR = 3'h2;
  localparam logic [2:0] TAP_TIMES_EIGHT = 3'h3;
  localparam logic [2:0] TAP_TIMES_SIXTEEN = 3'h4;
  localparam logic [4:0] PLL_CORE_FACTOR = 5'h10;

  // nominal frequencies in hertz
  localparam logic [31:0] SLOW_RC_HZ = 32'h0000_4E20;
  localparam logic [31:0] FAST_RC_HZ = 32'h00B7_1B00;
  localparam logic [31:0] CRYSTAL_MIN_HZ = 32'h003D_0900;
  localparam logic [31:0] CRYSTAL_MAX_HZ = 32'h00F4_2400;

  // clock switch settling time
  localparam int SETTLE_NS = 100;
  localparam int SYS_CLK_MHZ = 50;
  localparam int SETTLE_CYCLES = (SETTLE_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SETTLE_COUNT = 4'(SETTLE_CYCLES);

  // status register bits
  localparam int STAT_BOOTED_BIT = 0;
  localparam int STAT_SWITCHING_BIT = 1;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_REJECT_BIT = 3;

  localparam logic [31:0] MODE_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] source;
    logic [1:0] gain;
    logic pllOn;
    logic [2:0] tap;
  } clock_mode_type;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_SWITCH = 4'b0010,
    ST_RUN = 4'b0100,
    ST_RESWITCH = 4'b1000
  } phase_type;

endpackage : clock_select_pkg

// *** hdl/clock_freq_calc.sv ***
// computes system clock frequency from the applied mode
`timescale 1ns/1ps
module clock_freq_calc
  import clock_select_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire clock_mode_type mode,
  input wire logic [31:0] inputFrequency,
  output logic [31:0] sysFrequency
);

  logic [31:0] baseFrequency;
  logic [31:0] next_sysFrequency;

  // R1 R2 internal rc frequencies
  assign baseFrequency = (mode.source == SRC_INTERNAL_SLOW_RC) ? SLOW_RC_HZ :
                         (mode.source == SRC_INTERNAL_FAST_RC) ? FAST_RC_HZ : inputFrequency;
  // R9 tap factor scaling
  assign next_sysFrequency = mode.pllOn ? (baseFrequency << mode.tap) : baseFrequency;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sysFrequency <= FAST_RC_HZ;
    else
      sysFrequency <= next_sysFrequency;
  end

endmodule : clock_freq_calc

// *** hdl/system_clock_source_select.sv ***
// system clock source selector with wishbone configuration registers
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - internal rc oscillator offers slow near 20 kHz and fast near 12 MHz
// R2 - with no configuration loaded the fast internal rc runs
// R3 - after boot completes switch to the loaded mode, then release the application
// R4 - configuration may choose fast internal rc as well as slow internal rc
// R5 - low-gain crystal mode sets oscillator gain for 4 to 16 MHz crystals
// R6 - pll enabled only with external crystal or external clock sources
// R7 - enabled pll always multiplies the input frequency by sixteen internally
// R8 - system clock taken from one pll tap: 1, 2, 4, 8 or 16 times
// R9 - system frequency is input times tap factor, or input without pll
// R10 - mode held in a register; clock changes only when it is written
module system_clock_source_select
  import clock_select_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bootDone,
  input wire logic crystal_input_pin,
  output logic crystal_output_pin,
  output logic [2:0] clockSource,
  output logic [1:0] oscillatorGain,
  output logic pllEnable,
  output logic [4:0] pllCoreFactor,
  output logic [2:0] pllTap,
  output logic clockSwitching,
  output logic applicationRun
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  clock_mode_type modeReg;
  clock_mode_type applied;
  clock_mode_type writeMode;
  phase_type phase;
  phase_type next_phase;
  logic [31:0] inputFrequency;
  logic [31:0] sysFrequency;
  logic [3:0] settleCount;
  logic rejected;
  logic modeWritten;

  wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire hitMode = wb_adr_i == MODE_OFFSET;
  wire hitStatus = wb_adr_i == STATUS_OFFSET;
  wire hitFreq = wb_adr_i == FREQ_OFFSET;
  wire writeModeStrobe = busReq && wb_we_i && hitMode && wb_sel_i[0] && wb_sel_i[1];
  wire writeFreqStrobe = busReq && wb_we_i && hitFreq;
  wire [31:0] regMode = {17'h0_0000, modeReg.tap, 3'h0, modeReg.pllOn,
                         2'h0, modeReg.gain, 1'h0, modeReg.source};
  wire [31:0] regStatus = {28'h0, rejected, phase == ST_RUN,
                           clockSwitching, modeWritten};
  wire [31:0] readData = hitMode ? regMode : hitStatus ? regStatus :
                         hitFreq ? sysFrequency : 32'h0000_0000;

  // decode incoming mode word
  wire [2:0] wrSource = wb_dat_i[SOURCE_LSB +: 3];
  wire [1:0] wrGainRaw = wb_dat_i[GAIN_LSB +: 2];
  wire [2:0] wrTapRaw = wb_dat_i[TAP_LSB +: 3];
  wire wrExternal = (wrSource == SRC_CRYSTAL) || (wrSource == SRC_EXTERNAL_CLOCK);
  wire wrInternal = (wrSource == SRC_INTERNAL_FAST_RC) || (wrSource == SRC_INTERNAL_SLOW_RC);
  // R6 pll gated by source
  wire wrPllOn = wb_dat_i[PLL_ON_BIT] && wrExternal;
  wire wrBad = (!wrExternal && !wrInternal) || (wb_dat_i[PLL_ON_BIT] && !wrExternal)
               || (wrTapRaw > TAP_TIMES_SIXTEEN);

  // R4 both internal speeds selectable
  assign writeMode.source = (wrExternal || wrInternal) ? wrSource : SRC_INTERNAL_FAST_RC;
  // R5 crystal gain for 4 to 16 MHz
  assign writeMode.gain = (wrSource == SRC_CRYSTAL) ?
                          ((wrGainRaw == GAIN_OFF) ? GAIN_CRYSTAL_LOW : wrGainRaw) : GAIN_OFF;
  assign writeMode.pllOn = wrPllOn;
  // R8 tap limited to the five taps
  assign writeMode.tap = (wrTapRaw > TAP_TIMES_SIXTEEN) ? TAP_TIMES_ONE : wrTapRaw;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  wire settled = settleCount == 4'h0;

  always_comb
  begin
    next_phase = phase;
    case (phase)
      ST_BOOT:
        if (bootDone)
          next_phase = ST_SWITCH;
      ST_SWITCH:
        if (settled)
          next_phase = ST_RUN;
      ST_RUN:
        if (writeModeStrobe)
          next_phase = ST_RESWITCH;
      ST_RESWITCH:
        if (settled)
          next_phase = ST_RUN;
      default:
        next_phase = ST_BOOT;
    endcase
  end

  // R10 mode register storage
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      modeReg <= clock_mode_type'(MODE_RESET[8:0]);
    else if (writeModeStrobe)
      modeReg <= writeMode;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      modeWritten <= 1'b0;
    else if (writeModeStrobe)
      modeWritten <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      rejected <= 1'b0;
    else if (writeModeStrobe)
      rejected <= wrBad;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      inputFrequency <= CRYSTAL_MIN_HZ;
    else if (writeFreqStrobe)
      inputFrequency <= wb_dat_i;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      phase <= ST_BOOT;
    else
      phase <= next_phase;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      settleCount <= SETTLE_COUNT;
    else if ((phase == ST_BOOT && bootDone) || (phase == ST_RUN && writeModeStrobe))
      settleCount <= SETTLE_COUNT;
    else if (!settled)
      settleCount <= settleCount - 4'h1;
  end

  // R2 R3 fast rc until boot, then loaded mode
  // R10 applied after the boot switch and after each mode write, once settled
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      applied <= clock_mode_type'(MODE_RESET[8:0]);
    else if ((phase == ST_SWITCH || phase == ST_RESWITCH) && settled)
      applied <= modeReg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? readData : 32'h0000_0000;
    end
  end

  // R1 internal rc speeds encoded by source
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      clockSource <= SRC_INTERNAL_FAST_RC;
      oscillatorGain <= GAIN_OFF;
      pllEnable <= 1'b0;
      pllTap <= TAP_TIMES_ONE;
      pllCoreFactor <= 5'h00;
    end
    else
    begin
      clockSource <= applied.source;
      oscillatorGain <= applied.gain;
      pllEnable <= applied.pllOn;
      pllTap <= applied.tap;
      // R7 core times sixteen whenever pll is on, zero otherwise
      pllCoreFactor <= applied.pllOn ? PLL_CORE_FACTOR : 5'h00;
    end
  end

  // R3 application held until switch done
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      applicationRun <= 1'b0;
      clockSwitching <= 1'b0;
    end
    else
    begin
      applicationRun <= next_phase == ST_RUN || next_phase == ST_RESWITCH;
      clockSwitching <= next_phase == ST_SWITCH || next_phase == ST_RESWITCH;
    end
  end

  // crystal drive: inverting amplifier only with gain on
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      crystal_output_pin <= 1'b0;
    else
      crystal_output_pin <= (applied.gain != GAIN_OFF) && !crystal_input_pin;
  end

  // R9 frequency report
  clock_freq_calc freqCalc (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(applied),
    .inputFrequency(inputFrequency),
    .sysFrequency(sysFrequency)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  a_pll_needs_ext: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    pllEnable |-> (clockSource == SRC_CRYSTAL || clockSource == SRC_EXTERNAL_CLOCK))
    else $error("pll enabled with internal source");
  a_pll_core_sixteen: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    pllEnable |-> pllCoreFactor == PLL_CORE_FACTOR)
    else $error("pll core factor not sixteen");
  a_tap_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    pllTap <= TAP_TIMES_SIXTEEN)
    else $error("pll tap out of range");
  a_default_fast_rc: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    !modeWritten |-> ##2 clockSource == SRC_INTERNAL_FAST_RC)
    else $error("default source not fast rc");
  a_crystal_gain_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    clockSource == SRC_CRYSTAL |-> oscillatorGain != GAIN_OFF)
    else $error("crystal without gain");
  a_boot_then_run: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    (phase == ST_BOOT && bootDone) |-> ##[1:12] applicationRun)
    else $error("application not released after boot");
  a_no_run_in_boot: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    (phase == ST_BOOT) |-> !applicationRun)
    else $error("application running before boot");
  a_change_needs_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    (phase == ST_RUN && $past(phase) == ST_RUN && !$past(writeModeStrobe)) |-> $stable(applied))
    else $error("mode changed without write");
  a_freq_scaled: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    applied.pllOn |=> sysFrequency == ($past(inputFrequency) << $past(applied.tap)))
    else $error("system frequency not input times tap");
  a_ack_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_follows_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busReq |=> wb_ack_o)
    else $error("request not acknowledged");
  a_slow_rc_freq: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    applied.source == SRC_INTERNAL_SLOW_RC |=> sysFrequency == SLOW_RC_HZ)
    else $error("slow rc frequency wrong");
  a_fast_rc_freq: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    applied.source == SRC_INTERNAL_FAST_RC |=> sysFrequency == FAST_RC_HZ)
    else $error("fast rc frequency wrong");
  a_direct_freq: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    (!applied.pllOn && (applied.source == SRC_CRYSTAL || applied.source == SRC_EXTERNAL_CLOCK))
      |=> sysFrequency == $past(inputFrequency))
    else $error("system frequency not input frequency");
  a_osc_idle_low: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    applied.gain == GAIN_OFF |=> !crystal_output_pin)
    else $error("amplifier driving with gain off");
  a_run_after_switch: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    $fell(clockSwitching) |-> applicationRun)
    else $error("switch ended without application release");
  a_write_stores_mode: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    writeModeStrobe |=> modeReg == $past(writeMode))
    else $error("mode write not stored");

  c_boot_switch: cover property (@(posedge sys_clk) disable iff (!rst_n)
    phase == ST_SWITCH ##[1:12] phase == ST_RUN);
  c_pll_sixteen: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pllEnable && pllTap == TAP_TIMES_SIXTEEN);
  c_slow_rc: cover property (@(posedge sys_clk) disable iff (!rst_n)
    clockSource == SRC_INTERNAL_SLOW_RC && applicationRun);
  c_reject: cover property (@(posedge sys_clk) disable iff (!rst_n) rejected);

endmodule : system_clock_source_select

// *** dv/crystal_model.sv ***
// behavioural crystal on the crystal input pin
`timescale 1ns/1ps
module crystal_model
#(
  parameter int HALF_CYCLES = 5
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic crystal_output_pin,
  output logic crystal_input_pin
);
  int count;
  logic ringing;
  ////////////////////////////////////////////////////////////////////////
  // steady input frequency
  // the crystal needs one kick from the amplifier, then keeps ringing on its own
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      count <= 0;
      ringing <= 1'h0;
      crystal_input_pin <= 1'h0;
    end
    else if (!ringing)
      ringing <= crystal_output_pin;
    else if (count == HALF_CYCLES - 1)
    begin
      count <= 0;
      crystal_input_pin <= ~crystal_input_pin;
    end
    else
      count <= count + 1;
  end
endmodule : crystal_model

// *** dv/tb_top.sv ***
// self-checking bench for the system clock source selector
`timescale 1ns/1ps
module tb_top
  import clock_select_pkg::*;
;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, bootDone = 1'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] datI = 32'h0000_0000, datO, q;
  logic ack, oscIn, oscOut, pllEn, sw, run;
  logic [2:0] src, tap;
  logic [1:0] gain;
  logic [4:0] core;
  int miscompares = 0;
  int numChecks = 0;
  always #10 sys_clk = ~sys_clk;
  system_clock_source_select system_clock_source_select_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .bootDone(bootDone), .crystal_input_pin(oscIn),
    .crystal_output_pin(oscOut), .clockSource(src), .oscillatorGain(gain), .pllEnable(pllEn),
    .pllCoreFactor(core), .pllTap(tap), .clockSwitching(sw), .applicationRun(run));
  crystal_model crystal_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .crystal_output_pin(oscOut),
    .crystal_input_pin(oscIn));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d miscompares %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    datI <= d;
    @(posedge sys_clk);
    while (ack !== 1'h1)
      @(posedge sys_clk);
    q = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : wb
  task automatic settle();
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (sw !== 1'h0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 20, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
  endtask : settle
  task automatic mode(input logic [2:0] s, input logic [1:0] g, input logic p, input logic [2:0] t);
    wb(1'h1, MODE_OFFSET, 4'hF, {17'h0_0000, t, 3'h0, p, 2'h0, g, 1'h0, s});
    settle();
  endtask : mode
  task automatic freq(input logic [31:0] e);
    wb(1'h0, FREQ_OFFSET, 4'hF, 32'h0000_0000);
    chk(q, e);
  endtask : freq
  ////////////////////////////////////////////////////////////////////////
  task automatic test_boot();
    chk({src, gain, pllEn, core, run, sw, oscOut}, 14'h0000);
    wb(1'h1, FREQ_OFFSET, 4'hF, 32'h004C_4B40);
    bootDone <= 1'h1;
    settle();
    chk({src, run}, {SRC_INTERNAL_FAST_RC, 1'h1});
    wb(1'h0, STATUS_OFFSET, 4'hF, 32'h0000_0000);
    chk(q[STAT_RUN_BIT], 1'h1);
    freq(FAST_RC_HZ);
  endtask : test_boot
  task automatic test_slow();
    mode(SRC_INTERNAL_SLOW_RC, GAIN_OFF, 1'h0, TAP_TIMES_ONE);
    chk(src, SRC_INTERNAL_SLOW_RC);
    freq(SLOW_RC_HZ);
    mode(SRC_INTERNAL_FAST_RC, GAIN_OFF, 1'h0, TAP_TIMES_ONE);
    chk(src, SRC_INTERNAL_FAST_RC);
  endtask : test_slow
  task automatic test_crystal();
    logic prev;
    mode(SRC_CRYSTAL, GAIN_CRYSTAL_LOW, 1'h0, TAP_TIMES_ONE);
    chk({src, gain, pllEn}, {SRC_CRYSTAL, GAIN_CRYSTAL_LOW, 1'h0});
    @(posedge sys_clk);
    prev = oscIn;
    @(negedge sys_clk);
    chk(oscOut, !prev);
    freq(32'h004C_4B40);
  endtask : test_crystal
  task automatic test_pll();
    for (int t = 0; t < 5; t++)
    begin
      mode(SRC_CRYSTAL, GAIN_CRYSTAL_LOW, 1'h1, 3'(t));
      chk({pllEn, core, tap}, {1'h1, 5'h10, 3'(t)});
      freq(32'h004C_4B40 << t);
    end
  endtask : test_pll
  task automatic test_reject();
    mode(SRC_INTERNAL_FAST_RC, GAIN_OFF, 1'h1, TAP_TIMES_FOUR);
    chk({src, pllEn, core}, {SRC_INTERNAL_FAST_RC, 6'h00});
    wb(1'h0, STATUS_OFFSET, 4'hF, 32'h0000_0000);
    chk(q[STAT_REJECT_BIT], 1'h1);
    wb(1'h0, MODE_OFFSET, 4'hF, 32'h0000_0000);
    chk(q, {17'h0_0000, TAP_TIMES_FOUR, 12'h000});
    freq(FAST_RC_HZ);
  endtask : test_reject
  task automatic test_hold();
    wb(1'h1, 4'hC, 4'hF, 32'h0000_0001);
    wb(1'h1, MODE_OFFSET, 4'hC, 32'h0000_0001);
    repeat (8) @(posedge sys_clk);
    chk({src, sw}, {SRC_INTERNAL_FAST_RC, 1'h0});
    wb(1'h0, 4'hC, 4'hF, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask : test_hold
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    miscompares++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    test_boot();
    test_slow();
    test_crystal();
    test_pll();
    test_reject();
    test_hold();
    conclude();
  end
endmodule : tb_top
